// *** rtl/eps_core.sv ***
/*
 * Object dictionary, preset, limit switches and process value of the encoder
 * position block, with the bootloader download and program control entries.
 * Assumes a protocol layer on the same clock that presents one access at a
 * time and a telegram strobe from the PDO logic on the same clock.
 */
`include "eps_defs.svh"
`default_nettype none

// How it works
// (RULE1) second PDO map: default word, count two
// (RULE2) download subindex one streams image words out
// (RULE3) control value one starts, four erases
// (RULE4) position readable, writes refused
// (RULE5) bit zero selects counting direction
// (RULE6) bits one, two enable limits; reset zero
// (RULE7) steps per turn above hardware refused
// (RULE8) master keeps total within physical total
// (RULE9) master computes scaled total range correctly
// (RULE10) physical over scaled total is integer
// (RULE11) preset write makes position read preset
// (RULE12) preset above total range refused
// (RULE13) limits above total range refused; reset zero
// (RULE14) process value: position low, status top
// (RULE15) bit 30 set at or below minimum
// (RULE16) bit 31 set at maximum reached
// (RULE17) status bit zero while its limit disabled
// (RULE18) status bit clears once condition ends
module eps_core #(
	parameter logic [31:0] PHYS_TOTAL = `EPS_PHYS_TOTAL_DEF,
	parameter int TURN_BITS = `EPS_TURN_BITS_DEF
)(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// sensor word and telegram timing
	input wire logic [31:0] raw_pos,
	input wire logic tx_strobe,
	// object dictionary access
	input wire logic od_valid,
	input wire eps_pkg::eps_od_req_t od_req,
	output logic od_done,
	output eps_pkg::eps_od_rsp_t od_rsp,
	// process value for the telegram
	output logic [31:0] process_value,
	output logic pv_valid,
	// bootloader
	output logic [31:0] prog_data,
	output logic prog_valid,
	output logic prog_start,
	output logic prog_erase
);

	// ----------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------
	localparam logic [32:0] PHYS_STEPS = 33'h0_0000_0001 << TURN_BITS;

	logic [31:0] map_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] preset_reg;
	logic [7:0] op_reg;
	logic [31:0] spt_reg;
	logic [31:0] total_reg;
	logic [31:0] lower_reg;
	logic [31:0] upper_reg;
	logic [31:0] offset_reg;
	logic [31:0] offset_next;
	logic [31:0] dir_pos;
	logic [31:0] position;
	logic [31:0] code_next;
	logic [31:0] rdata_next;
	logic wr_ok;
	logic min_hit;
	logic max_hit;

	// true when a written value lies above the bound
	function automatic logic above(input logic [31:0] value, input logic [31:0] bound);
		above = value > bound;
	endfunction

	// true when the access targets this index and subindex
	function automatic logic hits(input logic [15:0] index, input logic [7:0] sub);
		hits = (od_req.index == index) && (od_req.sub == sub);
	endfunction

	// ----------------------------------------------------------------------
	// position pipeline
	// ----------------------------------------------------------------------
	eps_scaler #(
		.TURN_BITS(TURN_BITS)
	) u_scaler (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.raw_pin(raw_pos),
		.steps_per_turn(spt_reg),
		.total_range(total_reg),
		.ccw(op_reg[`EPS_OP_DIR_BIT]),
		.offset(offset_reg),
		.dir_pos(dir_pos),
		.position(position)
	);

	// ----------------------------------------------------------------------
	// access decode and answer
	// ----------------------------------------------------------------------
	always_comb
	begin
		code_next = `EPS_ABORT_NONE;
		rdata_next = 32'h0000_0000;
		case (od_req.index)
			`EPS_IDX_TPDO2_MAP:
				if (od_req.sub == `EPS_SUB_COUNT)
				begin
					rdata_next = `EPS_MAP_ENTRIES;
					if (od_req.wr)
						code_next = `EPS_ABORT_RO; // RULE1
				end
				else if (od_req.sub == `EPS_SUB_FIRST)
					rdata_next = map_reg;
				else
					code_next = `EPS_ABORT_NO_SUB;
			`EPS_IDX_PROG_AREA:
				if (od_req.sub == `EPS_SUB_COUNT)
				begin
					rdata_next = `EPS_PROG_ENTRIES;
					if (od_req.wr)
						code_next = `EPS_ABORT_RO;
				end
				else if (od_req.sub == `EPS_SUB_FIRST)
				begin
					if (!od_req.wr)
						code_next = `EPS_ABORT_WO; // RULE2
				end
				else
					code_next = `EPS_ABORT_NO_SUB;
			`EPS_IDX_PROG_CTRL:
				if (od_req.sub == `EPS_SUB_COUNT)
				begin
					rdata_next = `EPS_CTRL_ENTRIES;
					if (od_req.wr)
						code_next = `EPS_ABORT_RO;
				end
				else if (od_req.sub == `EPS_SUB_FIRST)
					rdata_next = ctrl_reg;
				else
					code_next = `EPS_ABORT_NO_SUB;
			`EPS_IDX_POSITION:
			begin
				rdata_next = position;
				if (od_req.wr)
					code_next = `EPS_ABORT_RO; // RULE4
			end
			`EPS_IDX_PRESET:
			begin
				rdata_next = preset_reg;
				if (od_req.wr && above(od_req.wdata, total_reg))
					code_next = `EPS_ABORT_RANGE; // RULE12
			end
			`EPS_IDX_OP_PARAM:
				rdata_next = {24'h00_0000, op_reg};
			`EPS_IDX_STEPS_TURN:
			begin
				rdata_next = spt_reg;
				if (od_req.wr && (od_req.wdata == 32'h0000_0000 ||
					above(od_req.wdata, PHYS_STEPS[31:0])))
					code_next = `EPS_ABORT_RANGE; // RULE7
			end
			`EPS_IDX_TOTAL:
			begin
				rdata_next = total_reg;
				if (od_req.wr && (od_req.wdata == 32'h0000_0000 ||
					above(od_req.wdata, PHYS_TOTAL)))
					code_next = `EPS_ABORT_RANGE; // RULE8
			end
			`EPS_IDX_LOWER:
			begin
				rdata_next = lower_reg;
				if (od_req.wr && above(od_req.wdata, total_reg))
					code_next = `EPS_ABORT_RANGE; // RULE13
			end
			`EPS_IDX_UPPER:
			begin
				rdata_next = upper_reg;
				if (od_req.wr && above(od_req.wdata, total_reg))
					code_next = `EPS_ABORT_RANGE; // RULE13
			end
			default:
				code_next = `EPS_ABORT_NO_OBJ;
		endcase
		// single-entry objects have no subindex other than zero
		if (od_req.index[15:12] == 4'h2 && od_req.sub != `EPS_SUB_COUNT)
			code_next = `EPS_ABORT_NO_SUB;
		if (code_next != `EPS_ABORT_NONE)
			rdata_next = 32'h0000_0000;
	end

	assign wr_ok = od_valid && od_req.wr && (code_next == `EPS_ABORT_NONE);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			od_done <= 1'b0;
			od_rsp <= '0;
		end
		else if (ce)
		begin
			od_done <= od_valid;
			if (od_valid)
			begin
				od_rsp.abort <= code_next != `EPS_ABORT_NONE;
				od_rsp.abort_code <= code_next;
				od_rsp.rdata <= rdata_next;
			end
		end
	end

	// ----------------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			map_reg <= `EPS_MAP_RESET; // RULE1
		else if (ce && wr_ok && hits(`EPS_IDX_TPDO2_MAP, `EPS_SUB_FIRST))
			map_reg <= od_req.wdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			op_reg <= `EPS_OP_RESET; // RULE6
		else if (ce && wr_ok && od_req.index == `EPS_IDX_OP_PARAM)
			op_reg <= od_req.wdata[7:0];
	end

	// scaling defaults to the physical resolution until the master changes it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			spt_reg <= PHYS_STEPS[31:0];
			total_reg <= PHYS_TOTAL;
		end
		else if (ce && wr_ok)
		begin
			if (od_req.index == `EPS_IDX_STEPS_TURN)
				spt_reg <= od_req.wdata; // RULE9
			if (od_req.index == `EPS_IDX_TOTAL)
				total_reg <= od_req.wdata; // RULE10
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lower_reg <= `EPS_LOWER_RESET;
			upper_reg <= `EPS_UPPER_RESET;
		end
		else if (ce && wr_ok)
		begin
			if (od_req.index == `EPS_IDX_LOWER)
				lower_reg <= od_req.wdata;
			if (od_req.index == `EPS_IDX_UPPER)
				upper_reg <= od_req.wdata;
		end
	end

	// ----------------------------------------------------------------------
	// preset
	// ----------------------------------------------------------------------
	// the offset is taken against the direction-corrected position, so a later
	// change of direction or scaling moves the reported value; preset again then
	always_comb
	begin
		if (od_req.wdata >= dir_pos)
			offset_next = od_req.wdata - dir_pos;
		else
			offset_next = 32'({1'b0, od_req.wdata} + {1'b0, total_reg} - {1'b0, dir_pos});
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			preset_reg <= `EPS_PRESET_RESET;
			offset_reg <= 32'h0000_0000;
		end
		else if (ce && wr_ok && od_req.index == `EPS_IDX_PRESET)
		begin
			preset_reg <= od_req.wdata;
			offset_reg <= offset_next; // RULE11
		end
	end

	// ----------------------------------------------------------------------
	// limit switches and process value
	// ----------------------------------------------------------------------
	assign min_hit = op_reg[`EPS_OP_MIN_BIT] && (position <= lower_reg); // RULE15 RULE17
	assign max_hit = op_reg[`EPS_OP_MAX_BIT] && (position >= upper_reg); // RULE16 RULE17

	// refreshed only per telegram, so a flag follows its condition each time
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			process_value <= 32'h0000_0000;
			pv_valid <= 1'b0;
		end
		else if (ce)
		begin
			pv_valid <= tx_strobe;
			if (tx_strobe)
				process_value <= {max_hit, min_hit, position[`EPS_PV_POS_MSB:0]}; // RULE14 RULE18
		end
	end

	// ----------------------------------------------------------------------
	// bootloader download and program control
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prog_data <= 32'h0000_0000;
			prog_valid <= 1'b0;
		end
		else if (ce)
		begin
			prog_valid <= wr_ok && hits(`EPS_IDX_PROG_AREA, `EPS_SUB_FIRST); // RULE2
			if (wr_ok && hits(`EPS_IDX_PROG_AREA, `EPS_SUB_FIRST))
				prog_data <= od_req.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= `EPS_CTRL_RESET;
			prog_start <= 1'b0;
			prog_erase <= 1'b0;
		end
		else if (ce)
		begin
			prog_start <= 1'b0;
			prog_erase <= 1'b0;
			if (wr_ok && hits(`EPS_IDX_PROG_CTRL, `EPS_SUB_FIRST))
			begin
				ctrl_reg <= od_req.wdata;
				prog_start <= od_req.wdata == `EPS_CTRL_START; // RULE3
				prog_erase <= od_req.wdata == `EPS_CTRL_ERASE; // RULE3
			end
		end
	end

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	map_count_ro_a: assert property ( // RULE1
		ce && od_valid && od_req.wr && hits(`EPS_IDX_TPDO2_MAP, `EPS_SUB_COUNT)
		|=> od_done && od_rsp.abort && od_rsp.abort_code == `EPS_ABORT_RO)
		else $error("map entry count accepted a write");

	map_count_read_a: assert property ( // RULE1
		ce && od_valid && !od_req.wr && hits(`EPS_IDX_TPDO2_MAP, `EPS_SUB_COUNT)
		|=> !od_rsp.abort && od_rsp.rdata == `EPS_MAP_ENTRIES)
		else $error("map entry count did not read two");

	image_word_fwd_a: assert property ( // RULE2
		ce && od_valid && od_req.wr && hits(`EPS_IDX_PROG_AREA, `EPS_SUB_FIRST)
		|=> prog_valid && prog_data == $past(od_req.wdata) && !od_rsp.abort)
		else $error("image word not passed to the bootloader");

	prog_start_pulse_a: assert property ( // RULE3
		ce && od_valid && od_req.wr && hits(`EPS_IDX_PROG_CTRL, `EPS_SUB_FIRST)
		&& od_req.wdata == `EPS_CTRL_START
		|=> prog_start && !prog_erase ##1 (!prog_start || $past(wr_ok)))
		else $error("start command did not pulse start once");

	prog_erase_pulse_a: assert property ( // RULE3
		ce && od_valid && od_req.wr && hits(`EPS_IDX_PROG_CTRL, `EPS_SUB_FIRST)
		&& od_req.wdata == `EPS_CTRL_ERASE
		|=> prog_erase && !prog_start)
		else $error("erase command did not pulse erase");

	position_ro_a: assert property ( // RULE4
		ce && od_valid && od_req.wr && od_req.index == `EPS_IDX_POSITION
		|=> od_rsp.abort && od_rsp.abort_code == `EPS_ABORT_RO)
		else $error("position accepted a write");

	steps_range_a: assert property ( // RULE7
		ce && od_valid && od_req.wr && hits(`EPS_IDX_STEPS_TURN, `EPS_SUB_COUNT)
		&& od_req.wdata > PHYS_STEPS[31:0]
		|=> od_rsp.abort && od_rsp.abort_code == `EPS_ABORT_RANGE && spt_reg == $past(spt_reg))
		else $error("oversized steps per turn not refused");

	preset_range_a: assert property ( // RULE12
		ce && od_valid && od_req.wr && hits(`EPS_IDX_PRESET, `EPS_SUB_COUNT)
		&& od_req.wdata > total_reg
		|=> od_rsp.abort_code == `EPS_ABORT_RANGE && preset_reg == $past(preset_reg))
		else $error("oversized preset not refused");

	limit_range_a: assert property ( // RULE13
		ce && od_valid && od_req.wr && od_req.sub == `EPS_SUB_COUNT
		&& (od_req.index == `EPS_IDX_LOWER || od_req.index == `EPS_IDX_UPPER)
		&& od_req.wdata > total_reg
		|=> od_rsp.abort && od_rsp.abort_code == `EPS_ABORT_RANGE)
		else $error("oversized limit not refused");

	pv_layout_a: assert property ( // RULE14
		ce && tx_strobe |=> pv_valid && process_value[29:0] == $past(position[29:0]))
		else $error("process value position field wrong");

	min_flag_a: assert property ( // RULE15
		ce && tx_strobe |=> process_value[`EPS_PV_MIN_BIT] ==
		($past(op_reg[`EPS_OP_MIN_BIT]) && $past(position) <= $past(lower_reg)))
		else $error("minimum status bit wrong");

	max_flag_a: assert property ( // RULE16
		ce && tx_strobe |=> process_value[`EPS_PV_MAX_BIT] ==
		($past(op_reg[`EPS_OP_MAX_BIT]) && $past(position) >= $past(upper_reg)))
		else $error("maximum status bit wrong");

	start_seen_c: cover property (ce && wr_ok ##1 prog_start);
	min_flag_seen_c: cover property (pv_valid && process_value[`EPS_PV_MIN_BIT]);
	preset_taken_c: cover property (wr_ok && od_req.index == `EPS_IDX_PRESET);

endmodule // eps_core

`default_nettype wire

// *** include/eps_defs.svh ***
/*
 * Constants for the encoder position scaling and limit block: object
 * dictionary indexes, subindexes, field positions, reset values and abort codes.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef EPS_DEFS_SVH
`define EPS_DEFS_SVH

// ----------------------------------------------------------------------
// object dictionary indexes
// ----------------------------------------------------------------------
`define EPS_IDX_TPDO2_MAP 16'h1a01
`define EPS_IDX_PROG_AREA 16'h1f50
`define EPS_IDX_PROG_CTRL 16'h1f51
`define EPS_IDX_POSITION 16'h2000
`define EPS_IDX_PRESET 16'h2013
`define EPS_IDX_OP_PARAM 16'h2100
`define EPS_IDX_STEPS_TURN 16'h2101
`define EPS_IDX_TOTAL 16'h2102
`define EPS_IDX_LOWER 16'h2104
`define EPS_IDX_UPPER 16'h2105

// ----------------------------------------------------------------------
// subindexes and fixed entry counts
// ----------------------------------------------------------------------
`define EPS_SUB_COUNT 8'h00
`define EPS_SUB_FIRST 8'h01
`define EPS_MAP_ENTRIES 32'h0000_0002
`define EPS_PROG_ENTRIES 32'h0000_0002
`define EPS_CTRL_ENTRIES 32'h0000_0002

// ----------------------------------------------------------------------
// reset values and command codes
// ----------------------------------------------------------------------
`define EPS_MAP_RESET 32'h6004_0020
`define EPS_CTRL_RESET 32'h0000_0000
`define EPS_PRESET_RESET 32'h0000_0000
`define EPS_OP_RESET 8'h00
`define EPS_LOWER_RESET 32'h0000_0000
`define EPS_UPPER_RESET 32'h0000_0000
`define EPS_CTRL_START 32'h0000_0001
`define EPS_CTRL_ERASE 32'h0000_0004

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define EPS_OP_DIR_BIT 0
`define EPS_OP_MIN_BIT 1
`define EPS_OP_MAX_BIT 2
`define EPS_PV_MIN_BIT 30
`define EPS_PV_MAX_BIT 31
`define EPS_PV_POS_MSB 29

// ----------------------------------------------------------------------
// abort codes
// ----------------------------------------------------------------------
`define EPS_ABORT_NONE 32'h0000_0000
`define EPS_ABORT_RANGE 32'h0609_0030
`define EPS_ABORT_RO 32'h0601_0002
`define EPS_ABORT_WO 32'h0601_0001
`define EPS_ABORT_NO_OBJ 32'h0602_0000
`define EPS_ABORT_NO_SUB 32'h0609_0011

// ----------------------------------------------------------------------
// physical sensor defaults
// ----------------------------------------------------------------------
`define EPS_PHYS_TOTAL_DEF 32'h0100_0000
`define EPS_TURN_BITS_DEF 12

`endif

// *** include/eps_pkg.sv ***
/*
 * Types shared by the encoder position block: object dictionary request and
 * answer words.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package eps_pkg;

	// one object dictionary access, as handed over by the protocol layer
	typedef struct packed {
		logic wr;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} eps_od_req_t;

	// answer: abort flag, abort code and read data
	typedef struct packed {
		logic abort;
		logic [31:0] abort_code;
		logic [31:0] rdata;
	} eps_od_rsp_t;

endpackage

`default_nettype wire

// *** rtl/eps_scaler.sv ***
/*
 * Position pipeline: synchronises the raw sensor word, scales it to user
 * steps, applies counting direction and adds the preset offset.
 * Assumes the raw word changes in a way that is safe to sample as a bus
 * (gray or held stable) and stays below the physical total steps.
 */
`include "eps_defs.svh"
`default_nettype none

module eps_scaler #(
	parameter int TURN_BITS = `EPS_TURN_BITS_DEF
)(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// raw sensor word from the pins
	input wire logic [31:0] raw_pin,
	// settings
	input wire logic [31:0] steps_per_turn,
	input wire logic [31:0] total_range,
	input wire logic ccw,
	input wire logic [31:0] offset,
	// results
	output logic [31:0] dir_pos,
	output logic [31:0] position
);

	logic [31:0] raw_meta_reg;
	logic [31:0] raw_sync_reg;
	logic [31:0] scaled_reg;
	logic [63:0] product;
	logic [32:0] sum;

	// physical steps per turn is a power of two, so the divide is a shift
	assign product = 64'(raw_sync_reg) * 64'(steps_per_turn);
	assign sum = {1'b0, dir_pos} + {1'b0, offset};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			raw_meta_reg <= 32'h0000_0000;
			raw_sync_reg <= 32'h0000_0000;
		end
		else if (ce)
		begin
			raw_meta_reg <= raw_pin;
			raw_sync_reg <= raw_meta_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			scaled_reg <= 32'h0000_0000;
		else if (ce)
			scaled_reg <= product[TURN_BITS +: 32];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dir_pos <= 32'h0000_0000;
		else if (ce)
			dir_pos <= ccw ? total_range - 32'h0000_0001 - scaled_reg : scaled_reg; // RULE5
	end

	// a preset leaves the offset no higher than the total range, so one subtraction wraps the sum
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			position <= 32'h0000_0000;
		else if (ce)
			position <= (sum >= {1'b0, total_range}) ?
				32'(sum - {1'b0, total_range}) : sum[31:0]; // RULE11
	end

endmodule // eps_scaler

`default_nettype wire

// *** sim/eps_master_model.sv ***
/*
 * Master model: issues one object dictionary access at a time.
 * Assumes the block answers with od_done within four cycles.
 */
`default_nettype none

module eps_master_model (
	// clock
	input wire logic clk,
	// access port
	input wire logic od_done,
	input wire eps_pkg::eps_od_rsp_t od_rsp,
	output logic od_valid,
	output eps_pkg::eps_od_req_t od_req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		od_valid = 1'b0;
		od_req = '0;
	end

	// a released request shows inverted bits, never the old value
	task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, output eps_pkg::eps_od_rsp_t r);
		int k;
		@(negedge clk);
		od_valid = 1'b1;
		od_req = {w, i, s, d};
		@(negedge clk);
		od_valid = 1'b0;
		od_req = ~od_req;
		for (k = 0; k < 4 && od_done !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		// no answer poisons the result so every compare fails
		r = (od_done === 1'b1) ? od_rsp : 'x;
	endtask
endmodule // eps_master_model

`default_nettype wire

// *** sim/encoder_position_scaling_limits_bench.sv ***
/*
 * Self-checking bench for eps_core: registers, refusals, bootloader
 * pulses, direction, scaling, preset and limit flags in the process value.
 * Assumes the default parameters: 4096 steps per turn, 2^24 total steps.
 */
`include "eps_defs.svh"
`default_nettype none

module encoder_position_scaling_limits_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk;
	logic rst_n;
	logic ce;
	logic [31:0] raw_pos;
	logic tx_strobe;
	logic od_valid;
	eps_pkg::eps_od_req_t od_req;
	logic od_done;
	eps_pkg::eps_od_rsp_t od_rsp;
	logic [31:0] process_value;
	logic pv_valid;
	logic [31:0] prog_data;
	logic prog_valid;
	logic prog_start;
	logic prog_erase;
	int mismatches = 0;
	int check_count = 0;
	int starts = 0;
	int erases = 0;
	int words = 0;

	eps_core i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .raw_pos(raw_pos),
		.tx_strobe(tx_strobe), .od_valid(od_valid), .od_req(od_req), .od_done(od_done),
		.od_rsp(od_rsp), .process_value(process_value), .pv_valid(pv_valid),
		.prog_data(prog_data), .prog_valid(prog_valid), .prog_start(prog_start),
		.prog_erase(prog_erase));

	eps_master_model i_master (.clk(clk), .od_done(od_done), .od_rsp(od_rsp),
		.od_valid(od_valid), .od_req(od_req));

	initial clk = 1'b0;
	always #20 clk = ~clk;

	// counted mid-cycle, where each one-cycle pulse is settled and seen once
	always @(negedge clk)
	begin
		if (prog_start === 1'b1) starts++;
		if (prog_erase === 1'b1) erases++;
		if (prog_valid === 1'b1) words++;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// write results are judged on the code only, reads on data too
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d, input logic [31:0] code, input logic [31:0] exp);
		eps_pkg::eps_od_rsp_t r;
		i_master.access(w, i, s, d, r);
		check(r.abort_code, code);
		if (!w) check(r.rdata, exp);
	endtask

	// settle lets the position pipeline catch up before the strobe
	task automatic tel(input logic [31:0] exp);
		int k;
		repeat (8) @(negedge clk);
		tx_strobe = 1'b1;
		@(negedge clk);
		tx_strobe = 1'b0;
		for (k = 0; k < 4 && pv_valid !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		check({31'h0, pv_valid}, 32'h1);
		check(process_value, exp);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		acc(0, `EPS_IDX_TPDO2_MAP, 0, 0, 0, 32'h2);
		acc(0, `EPS_IDX_TPDO2_MAP, 1, 0, 0, `EPS_MAP_RESET);
		acc(1, `EPS_IDX_TPDO2_MAP, 0, 32'h5, `EPS_ABORT_RO, 0);
		acc(1, `EPS_IDX_TPDO2_MAP, 1, 32'h6001_0020, 0, 0);
		acc(0, `EPS_IDX_TPDO2_MAP, 1, 0, 0, 32'h6001_0020);
		acc(0, `EPS_IDX_OP_PARAM, 0, 0, 0, 32'h0);
		acc(0, `EPS_IDX_PRESET, 0, 0, 0, 32'h0);
		acc(0, `EPS_IDX_LOWER, 0, 0, 0, 32'h0);
		acc(0, `EPS_IDX_UPPER, 0, 0, 0, 32'h0);
	endtask

	task automatic t_ranges;
		acc(1, `EPS_IDX_POSITION, 0, 32'h1, `EPS_ABORT_RO, 0);
		acc(1, `EPS_IDX_STEPS_TURN, 0, 32'd4097, `EPS_ABORT_RANGE, 0);
		acc(0, `EPS_IDX_STEPS_TURN, 0, 0, 0, 32'd4096);
		acc(1, `EPS_IDX_PRESET, 0, 32'h0100_0001, `EPS_ABORT_RANGE, 0);
		acc(1, `EPS_IDX_LOWER, 0, 32'h0100_0001, `EPS_ABORT_RANGE, 0);
		acc(1, `EPS_IDX_UPPER, 0, 32'h0100_0001, `EPS_ABORT_RANGE, 0);
		acc(0, `EPS_IDX_UPPER, 0, 0, 0, 32'h0);
	endtask

	task automatic t_boot;
		acc(1, `EPS_IDX_PROG_AREA, 1, 32'ha5a5_a5a5, 0, 0);
		acc(0, `EPS_IDX_PROG_AREA, 1, 0, `EPS_ABORT_WO, 0);
		acc(1, `EPS_IDX_PROG_CTRL, 1, `EPS_CTRL_START, 0, 0);
		acc(1, `EPS_IDX_PROG_CTRL, 1, `EPS_CTRL_ERASE, 0, 0);
		acc(1, `EPS_IDX_PROG_CTRL, 1, 32'h2, 0, 0);
		acc(0, `EPS_IDX_PROG_CTRL, 1, 0, 0, 32'h2);
		repeat (3) @(negedge clk);
		check(prog_data, 32'ha5a5_a5a5);
		check(words, 1);
		check(starts, 1);
		check(erases, 1);
	endtask

	task automatic t_limits;
		tel(32'd100);
		acc(1, `EPS_IDX_LOWER, 0, 32'd200, 0, 0);
		acc(1, `EPS_IDX_OP_PARAM, 0, 32'h2, 0, 0);
		tel(32'h4000_0064);
		acc(1, `EPS_IDX_LOWER, 0, 32'd100, 0, 0);
		tel(32'h4000_0064);
		acc(1, `EPS_IDX_LOWER, 0, 32'd99, 0, 0);
		tel(32'd100);
		acc(1, `EPS_IDX_LOWER, 0, 32'd200, 0, 0);
		acc(1, `EPS_IDX_OP_PARAM, 0, 32'h0, 0, 0);
		tel(32'd100);
		acc(1, `EPS_IDX_UPPER, 0, 32'd100, 0, 0);
		acc(1, `EPS_IDX_OP_PARAM, 0, 32'h4, 0, 0);
		tel(32'h8000_0064);
		acc(1, `EPS_IDX_UPPER, 0, 32'd101, 0, 0);
		tel(32'd100);
	endtask

	task automatic t_dir_scale;
		acc(1, `EPS_IDX_OP_PARAM, 0, 32'h1, 0, 0);
		tel(32'h00ff_ff9b);
		acc(0, `EPS_IDX_POSITION, 0, 0, 0, 32'h00ff_ff9b);
		acc(1, `EPS_IDX_OP_PARAM, 0, 32'h0, 0, 0);
		acc(1, `EPS_IDX_STEPS_TURN, 0, 32'd2048, 0, 0);
		acc(1, `EPS_IDX_TOTAL, 0, 32'h0080_0000, 0, 0);
		tel(32'd50);
		acc(1, `EPS_IDX_STEPS_TURN, 0, 32'd4096, 0, 0);
		acc(1, `EPS_IDX_TOTAL, 0, 32'h0100_0000, 0, 0);
	endtask

	task automatic t_preset;
		acc(1, `EPS_IDX_PRESET, 0, 32'd500, 0, 0);
		tel(32'd500);
		acc(0, `EPS_IDX_POSITION, 0, 0, 0, 32'd500);
		acc(0, `EPS_IDX_PRESET, 0, 0, 0, 32'd500);
	endtask

	// a strobe while the enable is low must leave the telegram untouched
	task automatic t_freeze;
		@(negedge clk);
		ce = 1'b0;
		tx_strobe = 1'b1;
		@(negedge clk);
		tx_strobe = 1'b0;
		repeat (2) @(negedge clk);
		check({31'h0, pv_valid}, 32'h0);
		check(process_value, 32'd500);
		ce = 1'b1;
		tel(32'd500);
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		raw_pos = 32'd100;
		tx_strobe = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_ranges();
		t_boot();
		t_limits();
		t_dir_scale();
		t_preset();
		t_freeze();
		results();
	end

	// far above the few hundred cycles the scenarios need
	initial
	begin
		#(20000 * 40);
		mismatches++;
		results();
	end
endmodule // encoder_position_scaling_limits_bench

`default_nettype wire
